// >>> rtl/zols_seq.sv
// What this block does
// (RULE_01) Loop setup pushes end, condition, start address
// (RULE_02) Entries carry two-bit loop type code
// (RULE_03) Test false at end-2 loops back
// (RULE_04) Test true falls through, pops both stacks
// (RULE_05) Counter decremented and tested at end-2
// (RULE_06) Reentry return skips the second decrement
// (RULE_07) Nested loops never share an end
// (RULE_08) No branches in a loop's last three
// (RULE_09) Non-delayed call allowed, not in short loops
// (RULE_10) End-2 never loads the counter from memory
// (RULE_11) Enough iterations run short loops without overhead
// (RULE_12) Short rare loops cancel two pipeline instructions
// (RULE_13) Interrupt held during those last passes
// (RULE_14) One-instruction loop holds interrupt third-from-last
// (RULE_15) One-instruction loop freezes fetch and opcode latch
// (RULE_16) Two-instruction loop tests on fetching its end
// (RULE_17) Outer condition loop ends two beyond inner
// (RULE_18) Abort jump avoids outer loop's last instruction
// (RULE_19) Three-instruction condition loop: one more pass
// (RULE_20) Two-instruction condition loop: one or two passes
// (RULE_21) One-instruction condition loop: three more executions
// (RULE_22) Count expires when decrement reaches final value
`timescale 1ns/1ps
`default_nettype none
module zols_seq (
   input wire logic mclk, // Core clock, 20 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state
   input wire logic exec_valid, // Execute stage holds a real instruction
   input wire logic [zols_pkg::AW-1:0] exec_pc, // Address in execute
   input wire logic [zols_pkg::AW-1:0] fetch_pc, // Address being fetched
   input wire logic setup_exec, // Loop setup instruction executes
   input wire logic [zols_pkg::AW-1:0] setup_end, // Its end address
   input wire logic [zols_pkg::TW-1:0] setup_term, // Its termination code
   input wire logic setup_is_count, // Terminates on count expiry
   input wire logic [zols_pkg::CW-1:0] pending_loop_count, // Count for the new loop
   input wire logic term_cond, // Running loop's arithmetic condition true
   input wire logic rts_lr_exec, // Return with loop_reentry_modifier executes
   input wire zols_pkg::zols_lent_t below_entry, // Entry under the top of the loop stack
   input wire logic [zols_pkg::CW-1:0] below_count, // Count under the top of the count stack
   input wire logic below_valid, // An outer loop exists
   output logic lstk_push, // Push loop address and count stacks
   output zols_pkg::zols_lent_t lstk_push_data, // Entry to push
   output logic pc_push, // Push return-address stack
   output logic [zols_pkg::AW-1:0] pc_push_addr, // Loop start address
   output logic pop_stacks, // Pop return-address and loop stacks
   output logic loop_back, // Next fetch from top of return-address stack
   output logic hold_fetch, // Freeze fetch address and opcode latch
   output logic cancel_fd, // Turn fetch and decode into no-operations
   output logic irq_hold, // Postpone interrupt processing this cycle
   output logic [zols_pkg::CW-1:0] current_iteration_count, // Count in effect
   output logic count_expired_condition // Count expired
);
   // Every check below runs on the core clock and sleeps in reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // ************************************************************
   // Loop context
   // ************************************************************
   zols_pkg::zols_state_t state_r, state_nxt;
   zols_pkg::zols_lent_t ent_r, ent_nxt;
   logic ovh_r, ovh_nxt; // Short loop that pays two overhead cycles
   logic short1_r, short1_nxt; // One-instruction condition loop
   logic short2_r, short2_nxt; // Two-instruction condition loop
   logic [1:0] rem_r, rem_nxt; // Passes left after a condition exit
   logic lr_skip_r, lr_skip_nxt; // Skip decrement after reentry
   logic first_r, first_nxt; // Condition seen at first instruction
   logic below_valid_seen; // Outer loop present when a short loop was cancelled

   // Type code from setup operands; also used for the short flags
   function automatic logic [1:0] loop_kind(input logic is_cnt, input logic [zols_pkg::AW-1:0] len);
      if (!is_cnt) begin
         loop_kind = zols_pkg::LT_COND;
      end else if (len == zols_pkg::A_ONE) begin
         loop_kind = zols_pkg::LT_LEN1;
      end else if (len == zols_pkg::A_TWO) begin
         loop_kind = zols_pkg::LT_LEN2;
      end else begin
         loop_kind = zols_pkg::LT_LONG;
      end
   endfunction

   // ************************************************************
   // Decode of the pipeline position
   // ************************************************************
   wire active = (state_r != zols_pkg::ZOLS_IDLE);
   wire [zols_pkg::AW-1:0] setup_len = setup_end - exec_pc;
   wire [1:0] setup_kind = loop_kind(setup_is_count, setup_len);
   wire [1:0] len_kind = loop_kind(1'b1, setup_len);
   wire setup = ce && setup_exec;
   wire setup_short = setup && (len_kind != zols_pkg::LT_LONG);
   wire at_end = ce && active && exec_valid && !setup_exec && exec_pc == ent_r.end_addr;
   wire at_em1 = ce && active && exec_valid && !setup_exec && exec_pc == ent_r.end_addr - zols_pkg::A_ONE;
   wire at_em2 = ce && active && exec_valid && !setup_exec && exec_pc == ent_r.end_addr - zols_pkg::A_TWO;
   wire fetch_end = ce && active && !setup_exec && fetch_pc == ent_r.end_addr;
   wire is_cnt = (ent_r.ltype != zols_pkg::LT_COND);
   wire is_len1 = (ent_r.ltype == zols_pkg::LT_LEN1);
   wire is_len2 = (ent_r.ltype == zols_pkg::LT_LEN2);
   wire is_long = (ent_r.ltype == zols_pkg::LT_LONG) || (!is_cnt && !short1_r && !short2_r);
   wire [zols_pkg::CW-1:0] cnt;
   wire cnt_at_one;
   wire cnt_exp;
   // The last three passes drain the pipe, so hold only while more than three remain, or more than one in an overhead loop
   wire cnt_big = (cnt == zols_pkg::C_ZERO) || (cnt > (ovh_r ? zols_pkg::C_ONE : zols_pkg::C_THREE));

   // ************************************************************
   // Long loops: test at end-2
   // ************************************************************
   // Three-instruction condition loops fall here too, end-2 is the start
   wire long_test = at_em2 && is_long; // [RULE_19]
   wire long_dec = long_test && is_cnt && !lr_skip_r; // [RULE_05] [RULE_06]
   wire long_term = is_cnt ? (lr_skip_r ? cnt_exp : cnt_at_one) : term_cond;
   wire long_back = long_test && !long_term; // [RULE_03]
   wire long_pop = long_test && long_term; // [RULE_04]

   // ************************************************************
   // One-instruction counter loops
   // ************************************************************
   // Fetch stays on the body while enough iterations remain
   wire l1_run = at_end && is_len1;
   wire l1_last = l1_run && cnt_at_one;
   wire l1_hold = l1_run && cnt_big; // [RULE_15] [RULE_11]
   wire l1_irq = l1_run && (ovh_r ? cnt_at_one : cnt == zols_pkg::C_THREE); // [RULE_13] [RULE_14]

   // ************************************************************
   // Two-instruction counter loops
   // ************************************************************
   // Fetching the end instruction triggers the test
   wire l2_test = fetch_end && is_len2 && !ovh_r; // [RULE_16]
   wire l2_back = l2_test && !cnt_at_one;
   wire l2_pop = l2_test && cnt_at_one;
   wire l2_last = at_end && is_len2 && ovh_r; // [RULE_12]
   wire l2_irq = (at_end || at_em1) && is_len2 && ovh_r; // [RULE_13]

   // ************************************************************
   // Short condition loops
   // ************************************************************
   // One instruction: tested every cycle, three more executions
   wire c1_run = at_end && !is_cnt && short1_r;
   wire c1_hold = c1_run && rem_r == zols_pkg::P_NONE; // [RULE_21]
   wire c1_pop = c1_run && rem_r == zols_pkg::P_ONE;
   // Two instructions: tested at the second, one or two passes follow
   wire c2_test = at_end && !is_cnt && short2_r && rem_r == zols_pkg::P_NONE && term_cond;
   wire [1:0] c2_passes = first_r ? zols_pkg::P_ONE : zols_pkg::P_TWO; // [RULE_20]
   wire c2_back = fetch_end && !is_cnt && short2_r && rem_r == zols_pkg::P_NONE && !(c2_test && first_r);
   wire c2_pop = at_end && !is_cnt && short2_r && rem_r == zols_pkg::P_ONE;

   // ************************************************************
   // Pipeline and stack strobes
   // ************************************************************
   wire cancel = l1_last && ovh_r || l2_last; // [RULE_12]
   wire pop = long_pop || l1_last || l2_pop || l2_last || c1_pop || c2_pop; // [RULE_04]
   wire cnt_dec = long_dec || l1_run || l2_test;

   assign lstk_push = setup; // [RULE_01]
   assign lstk_push_data = '{ltype: setup_kind, term: setup_term, end_addr: setup_end}; // [RULE_02]
   assign pc_push = setup; // [RULE_01]
   assign pc_push_addr = exec_pc + zols_pkg::A_ONE;
   assign pop_stacks = pop;
   // Short loops already loop back while their setup executes
   assign loop_back = setup_short || long_back || l2_back || c2_back; // [RULE_03]
   // A one-instruction body must stay in decode from its setup on
   assign hold_fetch = l1_hold || c1_hold || setup && len_kind == zols_pkg::LT_LEN1; // [RULE_15]
   assign cancel_fd = cancel;
   assign irq_hold = l1_irq || l2_irq || (ce && state_r == zols_pkg::ZOLS_NOP); // [RULE_13]

   // ************************************************************
   // Counter; two-instruction setup counts its first test at once
   // ************************************************************
   wire cnt_load = setup && setup_is_count || pop && below_valid;
   wire [zols_pkg::CW-1:0] setup_cnt = (setup_kind == zols_pkg::LT_LEN2) ? pending_loop_count - zols_pkg::C_ONE
                                                                          : pending_loop_count;
   wire [zols_pkg::CW-1:0] load_val = setup ? setup_cnt : below_count;

   zols_cnt u_cnt (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .load(cnt_load),
      .load_val(load_val),
      .dec(cnt_dec && !cnt_load), // [RULE_05]
      .count(cnt),
      .at_one(cnt_at_one),
      .expired(cnt_exp)
   );
   assign current_iteration_count = cnt;
   assign count_expired_condition = cnt_exp;

   // ************************************************************
   // Next context
   // ************************************************************
   // Overhead only when too few iterations remain to fill the pipe
   always_comb begin
      state_nxt = state_r;
      ent_nxt = ent_r;
      ovh_nxt = ovh_r;
      short1_nxt = short1_r;
      short2_nxt = short2_r;
      rem_nxt = rem_r;
      lr_skip_nxt = lr_skip_r;
      first_nxt = first_r;
      // A reentry landing on the test cycle wins over the clear
      if (long_test) begin
         lr_skip_nxt = 1'b0;
      end
      if (rts_lr_exec && ce) begin
         lr_skip_nxt = 1'b1; // [RULE_06]
      end
      if (at_em1) begin
         first_nxt = term_cond;
      end
      if (c1_run && rem_r == zols_pkg::P_NONE && term_cond) begin
         rem_nxt = zols_pkg::P_THREE; // [RULE_21]
      end else if (c2_test) begin
         rem_nxt = c2_passes; // [RULE_20]
      end else if ((c1_run || at_end && short2_r) && rem_r != zols_pkg::P_NONE) begin
         rem_nxt = rem_r - zols_pkg::P_ONE;
      end
      case (state_r)
         zols_pkg::ZOLS_NOP: begin
            state_nxt = active && ent_r.end_addr != exec_pc && below_valid_seen ? zols_pkg::ZOLS_LOOP
                                                                                : zols_pkg::ZOLS_IDLE;
         end
         default: begin
            if (cancel) begin
               state_nxt = zols_pkg::ZOLS_NOP;
            end else if (pop) begin
               state_nxt = below_valid ? zols_pkg::ZOLS_LOOP : zols_pkg::ZOLS_IDLE;
            end
         end
      endcase
      if (pop) begin
         ent_nxt = below_entry;
         ovh_nxt = 1'b0;
         short1_nxt = 1'b0;
         short2_nxt = 1'b0;
         rem_nxt = zols_pkg::P_NONE;
         lr_skip_nxt = 1'b0;
      end
      if (setup) begin
         state_nxt = zols_pkg::ZOLS_LOOP;
         ent_nxt = lstk_push_data;
         ovh_nxt = (setup_kind == zols_pkg::LT_LEN1) && (pending_loop_count == zols_pkg::C_ONE
                   || pending_loop_count == zols_pkg::C_TWO)
                   || (setup_kind == zols_pkg::LT_LEN2) && pending_loop_count == zols_pkg::C_ONE; // [RULE_11]
         short1_nxt = !setup_is_count && len_kind == zols_pkg::LT_LEN1;
         short2_nxt = !setup_is_count && len_kind == zols_pkg::LT_LEN2;
         rem_nxt = zols_pkg::P_NONE;
         lr_skip_nxt = 1'b0;
      end
   end

   // Outer loop presence kept through the no-operation cycle
   logic bvs_nxt;
   assign bvs_nxt = cancel ? below_valid : below_valid_seen;

   // Context registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= zols_pkg::ZOLS_IDLE;
         ent_r <= '0;
         ovh_r <= 1'b0;
         short1_r <= 1'b0;
         short2_r <= 1'b0;
         rem_r <= zols_pkg::P_NONE;
         lr_skip_r <= 1'b0;
         first_r <= 1'b0;
         below_valid_seen <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         ent_r <= ent_nxt;
         ovh_r <= ovh_nxt;
         short1_r <= short1_nxt;
         short2_r <= short2_nxt;
         rem_r <= rem_nxt;
         lr_skip_r <= lr_skip_nxt;
         first_r <= first_nxt;
         below_valid_seen <= bvs_nxt;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   AST_SETUP_PUSH: assert property (setup_exec && ce // [RULE_01]
      |-> lstk_push && pc_push && pc_push_addr == exec_pc + 24'h000001)
      else $error("setup did not push both stacks");
   AST_COND_TYPE: assert property (lstk_push && !setup_is_count // [RULE_02]
      |-> lstk_push_data.ltype == zols_pkg::LT_COND)
      else $error("condition loop pushed with counter type");
   AST_LONG_BACK: assert property (at_em2 && is_long && !is_cnt && !term_cond // [RULE_03]
      |-> loop_back && !pop_stacks)
      else $error("false test did not loop back");
   AST_LONG_POP: assert property (at_em2 && is_long && !is_cnt && term_cond |-> pop_stacks && !loop_back) // [RULE_04]
      else $error("true test did not fall through");
   AST_LONG_DEC: assert property (long_test && is_cnt && !lr_skip_r && !setup_exec // [RULE_05]
      |=> current_iteration_count == $past(current_iteration_count) - 32'h00000001)
      else $error("counter not decremented at end-2");
   AST_LR_SKIP: assert property (long_test && lr_skip_r // [RULE_06]
      |=> $stable(current_iteration_count) && !lr_skip_r)
      else $error("reentry decremented twice");
   AST_CANCEL_NOP: assert property (cancel_fd |=> irq_hold && state_r == zols_pkg::ZOLS_NOP) // [RULE_12]
      else $error("cancel not followed by held no-operation cycle");
   AST_IRQ_THIRD: assert property (l1_run && !ovh_r && current_iteration_count == 32'h00000003 // [RULE_14]
      |-> irq_hold)
      else $error("interrupt not held at third-from-last pass");
   AST_HOLD_FETCH: assert property (l1_run && current_iteration_count > 32'h00000003 |-> hold_fetch) // [RULE_15]
      else $error("one-instruction loop released fetch early");
   AST_C1_PASSES: assert property (c1_run && rem_r == 2'h0 && term_cond && !pop_stacks // [RULE_21]
      |=> rem_r == 2'h3)
      else $error("one-instruction condition loop exit count wrong");

   CV_LONG_POP: cover property (long_pop && is_cnt);
   CV_L1_OVH: cover property (l1_last && ovh_r);
   CV_L2_OVH: cover property (l2_last);
   CV_C2_TWO: cover property (c2_test && !first_r);
endmodule
`default_nettype wire

// >>> rtl/zols_pkg.sv
package zols_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int AW = 24;
   localparam int CW = 32;
   localparam int TW = 5;

   // ************************************************************
   // Loop type codes carried in each loop stack entry
   // ************************************************************
   localparam logic [1:0] LT_COND = 2'h0; // Arithmetic condition
   localparam logic [1:0] LT_LEN1 = 2'h1; // Counter, one instruction
   localparam logic [1:0] LT_LEN2 = 2'h2; // Counter, two instructions
   localparam logic [1:0] LT_LONG = 2'h3; // Counter, three or more

   // ************************************************************
   // Address offsets, counts and pass figures
   // ************************************************************
   localparam logic [AW-1:0] A_ONE = 24'h000001;
   localparam logic [AW-1:0] A_TWO = 24'h000002;
   localparam logic [CW-1:0] C_ZERO = 32'h00000000;
   localparam logic [CW-1:0] C_ONE = 32'h00000001;
   localparam logic [CW-1:0] C_TWO = 32'h00000002;
   localparam logic [CW-1:0] C_THREE = 32'h00000003;
   localparam logic [CW-1:0] C_RESET = 32'hffffffff; // No loop running
   localparam logic [1:0] P_NONE = 2'h0;
   localparam logic [1:0] P_ONE = 2'h1;
   localparam logic [1:0] P_TWO = 2'h2;
   localparam logic [1:0] P_THREE = 2'h3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic [1:0] ltype;
      logic [TW-1:0] term;
      logic [AW-1:0] end_addr;
   } zols_lent_t;

   typedef enum logic [1:0] {ZOLS_IDLE, ZOLS_LOOP, ZOLS_NOP} zols_state_t;
endpackage

// >>> rtl/zols_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Current iteration counter with count-expired flag
// ************************************************************
module zols_cnt (
   input wire logic mclk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic load, // Load a new count
   input wire logic [zols_pkg::CW-1:0] load_val, // Value to load
   input wire logic dec, // Decrement for this iteration
   output logic [zols_pkg::CW-1:0] count, // Current iteration count
   output logic at_one, // Next decrement expires the loop
   output logic expired // Count expired condition
);
   logic [zols_pkg::CW-1:0] cnt_r;
   logic [zols_pkg::CW-1:0] cnt_nxt;
   logic exp_r;
   logic exp_nxt;

   // Next count: load wins; loading a zero count raises the expired flag at once
   assign at_one = (cnt_r == zols_pkg::C_ONE);
   assign cnt_nxt = load ? load_val : (dec ? cnt_r - zols_pkg::C_ONE : cnt_r);
   assign exp_nxt = load ? (load_val == zols_pkg::C_ZERO) : (dec ? at_one : exp_r); // [RULE_22]

   // Counter state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_r <= zols_pkg::C_RESET;
         exp_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign count = cnt_r;
   assign expired = exp_r;

   // Expiry follows the decrement that reaches zero
   AST_CNT_EXPIRE: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE_22]
      ce && dec && !load && at_one |=> expired && count == zols_pkg::C_ZERO)
      else $error("count expired flag not raised at final decrement");
endmodule
`default_nettype wire

// >>> dv/zols_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Fetch, decode and execute pipeline facing the loop sequencer
// ************************************************************
module zols_pipe_model (
   input wire logic mclk, // Core clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic jump, // Redirect fetch, bench stimulus
   input wire logic [zols_pkg::AW-1:0] jump_addr, // Redirect target
   input wire logic pc_push, // Push of the loop start address
   input wire logic [zols_pkg::AW-1:0] pc_push_addr, // Pushed address
   input wire logic loop_back, // Fetch from top of return-address stack
   input wire logic hold_fetch, // Keep fetch address and opcode latch
   input wire logic cancel_fd, // Kill fetch and decode
   output logic [zols_pkg::AW-1:0] fetch_pc, // Address being fetched
   output logic [zols_pkg::AW-1:0] exec_pc, // Address in execute
   output logic exec_valid // Execute holds a real instruction
);
   logic [zols_pkg::AW-1:0] dec_pc_r;
   logic [zols_pkg::AW-1:0] top_r;
   logic dec_valid_r;
   wire logic [zols_pkg::AW-1:0] top_w;
   // Forward a push made in the same cycle, short loops loop back at setup
   assign top_w = pc_push ? pc_push_addr : top_r;
   // Program is straight-line code: no branch, counter load or shared end in loop tails
   always @(posedge mclk) begin
      if (!rst_n) begin
         fetch_pc <= 24'h000000;
         dec_pc_r <= 24'h000000;
         exec_pc <= 24'h000000;
         exec_valid <= 1'b0;
         dec_valid_r <= 1'b0;
         top_r <= 24'hffffff;
      end else begin
         if (pc_push) begin
            top_r <= pc_push_addr;
         end
         exec_pc <= dec_pc_r;
         exec_valid <= dec_valid_r & !cancel_fd & !jump;
         if (!hold_fetch) begin
            dec_pc_r <= fetch_pc;
         end
         dec_valid_r <= !cancel_fd & !jump;
         fetch_pc <= jump ? jump_addr : loop_back ? top_w : hold_fetch ? fetch_pc : fetch_pc + 24'h000001;
      end
   end
endmodule
`default_nettype wire

// >>> dv/zero_overhead_loop_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module zero_overhead_loop_sequencer_test;
   logic mclk, rst_n, setup_exec, setup_is_count, term_cond, jump, rts_lr;
   logic [zols_pkg::AW-1:0] setup_end, jump_addr, exec_pc, fetch_pc, pc_push_addr;
   logic [zols_pkg::TW-1:0] setup_term;
   logic [zols_pkg::CW-1:0] pending_loop_count, current_iteration_count;
   logic exec_valid, lstk_push, pc_push, pop_stacks, loop_back, hold_fetch, cancel_fd, irq_hold;
   logic count_expired_condition;
   zols_pkg::zols_lent_t lstk_push_data;
   int fails, checks_done, cycles, lr_at;
   zols_seq uut (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .exec_valid(exec_valid), .exec_pc(exec_pc),
      .fetch_pc(fetch_pc), .setup_exec(setup_exec), .setup_end(setup_end), .setup_term(setup_term),
      .setup_is_count(setup_is_count), .pending_loop_count(pending_loop_count), .term_cond(term_cond),
      .rts_lr_exec(rts_lr), .below_entry('0), .below_count(32'h00000000), .below_valid(1'b0),
      .lstk_push(lstk_push), .lstk_push_data(lstk_push_data), .pc_push(pc_push),
      .pc_push_addr(pc_push_addr), .pop_stacks(pop_stacks), .loop_back(loop_back),
      .hold_fetch(hold_fetch), .cancel_fd(cancel_fd), .irq_hold(irq_hold),
      .current_iteration_count(current_iteration_count), .count_expired_condition(count_expired_condition));
   zols_pipe_model pipe (.mclk(mclk), .rst_n(rst_n), .jump(jump), .jump_addr(jump_addr), .pc_push(pc_push),
      .pc_push_addr(pc_push_addr), .loop_back(loop_back), .hold_fetch(hold_fetch), .cancel_fd(cancel_fd),
      .fetch_pc(fetch_pc), .exec_pc(exec_pc), .exec_valid(exec_valid));
   // ************************************************************
   // Clock and hang guard
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Whole run is well under a thousand cycles, so this only fires on a hang
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails = fails + 1;
         end_of_test();
      end
   end
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Jump to n, execute a setup there, then tally strobes over the loop's life
   task automatic run_loop(input logic [23:0] n, input logic [23:0] e, input logic cnt, input logic [31:0] num,
      input int k, input logic [1:0] lt, output int ne, output int nb, output int np, output int nc,
      output int ni);
      ne = 0; nb = 0; np = 0; nc = 0; ni = 0;
      jump = 1'b1;
      jump_addr = n;
      @(posedge mclk);
      #1 jump = 1'b0;
      repeat (4) begin
         if (!(exec_valid === 1'b1 && exec_pc === n)) begin
            @(posedge mclk);
            #1;
         end
      end
      setup_exec = 1'b1;
      setup_end = e;
      setup_term = 5'h0f;
      setup_is_count = cnt;
      pending_loop_count = num;
      #1 check({31'h0, lstk_push}, 32'h1, "loop stack push");
      check({31'h0, pc_push}, 32'h1, "start push");
      check({8'h0, pc_push_addr}, {8'h0, n + 24'h000001}, "start address");
      check({1'b0, lstk_push_data}, {1'b0, lt, 5'h0f, e}, "stack entry");
      repeat (40) begin
         @(posedge mclk);
         #1 setup_exec = 1'b0;
         // Condition rises during the k-th execution of the end and then stays true
         term_cond = (k > 0) && (ne >= k || ne == k - 1 && exec_valid && exec_pc === e);
         rts_lr = (ne == lr_at) && exec_valid && exec_pc === e - 24'h000001;
         #1;
         if (exec_valid === 1'b1 && exec_pc === e) ne = ne + 1;
         if (loop_back === 1'b1) nb = nb + 1;
         if (pop_stacks === 1'b1) np = np + 1;
         if (cancel_fd === 1'b1) nc = nc + 1;
         if (irq_hold === 1'b1) ni = ni + 1;
         if (ne == 1 && exec_pc === e - 24'h000002 && cnt && lt == zols_pkg::LT_LONG && exec_valid) begin
            check(current_iteration_count, num - 32'h1, "count after first end-2");
         end
      end
      term_cond = 1'b0;
      rts_lr = 1'b0;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic test_reset();
      check(current_iteration_count, zols_pkg::C_RESET, "idle count");
      check({31'h0, count_expired_condition}, 32'h0, "idle expired");
   endtask
   task automatic test_long_count();
      int ne, nb, np, nc, ni;
      run_loop(24'h000010, 24'h000014, 1'b1, 32'h2, 0, zols_pkg::LT_LONG, ne, nb, np, nc, ni);
      check(ne, 2, "long passes");
      check(nb, 1, "long loop-backs");
      check(np, 1, "long pops");
      check(nc, 0, "long cancels");
   endtask
   // A reentry return at end-1 of the first pass repeats that pass without spending a count
   task automatic test_lr_reentry();
      int ne, nb, np, nc, ni;
      lr_at = 0;
      run_loop(24'h000020, 24'h000024, 1'b1, 32'h3, 0, zols_pkg::LT_LONG, ne, nb, np, nc, ni);
      lr_at = -1;
      check(ne, 4, "reentry passes");
      check(np, 1, "reentry pops");
   endtask
   task automatic test_short_count(input logic [23:0] len, input logic [31:0] num, input int exp_nc,
      input int exp_ni);
      int ne, nb, np, nc, ni;
      run_loop(24'h000040, 24'h000040 + len, 1'b1, num, 0, len[1:0], ne, nb, np, nc, ni);
      check(ne, num, "short passes");
      check(np, 1, "short pops");
      check(nc, exp_nc, "short cancels");
      check(ni, exp_ni, "short irq holds");
   endtask
   task automatic test_cond(input logic [23:0] len, input int k, input int exp_ne);
      int ne, nb, np, nc, ni;
      run_loop(24'h000080, 24'h000080 + len, 1'b0, 32'h0, k, zols_pkg::LT_COND, ne, nb, np, nc, ni);
      check(ne, exp_ne, "cond passes");
      check(np, 1, "cond pops");
   endtask
   initial begin
      rst_n = 1'b0; setup_exec = 1'b0; setup_is_count = 1'b0; term_cond = 1'b0; jump = 1'b0;
      setup_end = 24'h000000; setup_term = 5'h00; pending_loop_count = 32'h0; jump_addr = 24'h000000;
      fails = 0; checks_done = 0; cycles = 0; lr_at = -1; rts_lr = 1'b0;
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'b1;
      test_reset();
      test_long_count();
      test_lr_reentry();
      test_short_count(24'h1, 32'h2, 1, 2);
      test_short_count(24'h1, 32'h4, 0, 1);
      test_short_count(24'h2, 32'h1, 1, 3);
      test_short_count(24'h2, 32'h2, 0, 0);
      test_cond(24'h1, 2, 5);
      test_cond(24'h2, 2, 4);
      test_cond(24'h3, 2, 3);
      end_of_test();
   end
endmodule
`default_nettype wire
